// File: ecd_pkg.sv
package ecd_pkg;
    // register offsets
    localparam logic [15:0] ECD_WEN_ADDR = 16'h0E00;
    localparam logic [15:0] ECD_COND_ADDR = 16'h0E01;
    localparam logic [15:0] ECD_SAVE_ADDR = 16'h0E02;
    localparam logic [15:0] ECD_LOAD_ADDR = 16'h0E03;
    localparam logic [15:0] ECD_STAT_ADDR = 16'h0E04;
    // field positions
    localparam int ECD_WEN_BIT = 0;
    localparam int ECD_SAVE_BIT = 1 - 1;
    localparam int ECD_LOAD_BIT = 1;
    // storage
    localparam int ECD_MEM_BYTES = 2048;
    localparam int ECD_EA_W = 11;
    // instruction codes
    localparam logic [7:0] ECD_OP_DMAX = 8'h7F;
    localparam logic [7:0] ECD_OP_IOUPD = 8'h80;
    localparam logic [7:0] ECD_OP_CAL = 8'h0A;
    localparam logic [7:0] ECD_OP_NULL = 8'hB0;
    localparam logic [7:0] ECD_OP_CMAX = 8'hCF;
    localparam logic [7:0] ECD_OP_PAUSE = 8'hFE;
    localparam logic [7:0] ECD_OP_END = 8'hFF;

    typedef enum logic [3:0] {
        ECD_IDLE, ECD_DL_OP, ECD_DL_AH, ECD_DL_AL, ECD_DL_DAT, ECD_DL_CK,
        ECD_UP_OP, ECD_UP_AH, ECD_UP_AL, ECD_UP_DAT, ECD_UP_CK
    } ecd_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ecd_bus_t;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } ecd_map_t;

    typedef struct packed {
        ecd_state_t st;
        logic wen;
        logic [4:0] condSel;
        logic [4:0] strap;
        logic strapTaken;
        logic [4:0] cond;
        logic [31:0] tags;
        logic [ECD_EA_W-1:0] eePtr;
        logic [7:0] spPtr;
        logic [7:0] cnt;
        logic exec;
        logic [7:0] sum;
        logic [15:0] tgt;
        logic fault;
        logic done;
        logic [7:0] rdData;
        ecd_map_t map;
        logic ioUpd;
        logic cal;
    } ecd_regs_t;
endpackage

// File: ecd_download_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - upload copies condition instructions to storage unchanged, no effect
// - download always executes condition and end instructions
// - condition is 5 bits; zero means execute everything
// - condition is the select field if nonzero, else latched straps
// - codes B1..CF tag conditions 1..31 on the tag board
// - code B0 clears the whole tag board
// - with condition and tags set, execute only if condition tagged
// - untagged condition skips instructions, including data and checksum
// - any combination of the 31 tags can be held at once
// - 0x80 is I/O update, 0x0A is calibrate, both conditional
// - save bit 0 starts an upload of the scratch pad
// - load bit 1 starts a download using the selected condition
// - power-up runs an automatic download with the strap condition
// - storage holds 2048 bytes, non-data instructions take one, pause (FE) none
// - a data instruction stores opcode, address, N bytes, checksum
// - codes 00..7F except 0A move code plus one bytes from a two-byte address
// - checksum mismatch sets fault; all matching sets complete
// - automatic download only when strap condition is nonzero
module ecd_download_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input ecd_pkg::ecd_bus_t bus,
    output logic [7:0] busRdData,
    // power-up straps
    input wire logic [4:0] conditionStrapPins,
    // scratch pad read port, data follows spAddr in the same cycle
    output logic [7:0] spAddr,
    input wire logic [7:0] spData,
    // register map port, read data follows mapPort.addr
    output ecd_pkg::ecd_map_t mapPort,
    input wire logic [7:0] mapRdData,
    // command pulses
    output logic ioUpdate,
    output logic calibrate
);
    import ecd_pkg::*;
    ecd_regs_t r;
    ecd_regs_t next_r;
    logic [7:0] mem [ECD_MEM_BYTES];
    logic memWe;
    logic [7:0] memData;
    logic [7:0] rdByte;
    logic [4:0] condIdx;
    logic startDl;
    logic startUp;
    logic execNow;
    function automatic logic isCond(input logic [7:0] b);
        return b >= ECD_OP_NULL && b <= ECD_OP_CMAX;
    endfunction
    // data codes exclude the calibrate code, which overlaps that range
    function automatic logic isData(input logic [7:0] b);
        return b <= ECD_OP_DMAX && b != ECD_OP_CAL;
    endfunction
    function automatic logic condExec(input logic [4:0] c,
                                      input logic [31:0] t);
        return c == 5'h00 || t == 32'h0000_0000 || t[c];
    endfunction
    assign rdByte = mem[r.eePtr];
    assign condIdx = 5'(rdByte - ECD_OP_NULL);
    assign execNow = condExec(r.cond, r.tags);
    // the automatic load is armed once, at the first edge after reset
    assign startDl = r.st == ECD_IDLE && ((!r.strapTaken
        && conditionStrapPins != 5'h00)
        || (r.strapTaken && bus.wr && bus.addr == ECD_LOAD_ADDR
        && bus.wdata[ECD_LOAD_BIT]));
    assign startUp = r.st == ECD_IDLE && r.strapTaken && r.wen && bus.wr
        && bus.addr == ECD_SAVE_ADDR && bus.wdata[ECD_SAVE_BIT];
    always_comb
    begin
        next_r = r;
        next_r.map.wr = 1'b0;
        next_r.ioUpd = 1'b0;
        next_r.cal = 1'b0;
        next_r.rdData = 8'h00;
        memWe = 1'b0;
        memData = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                ECD_WEN_ADDR: next_r.rdData = {7'h00, r.wen};
                ECD_COND_ADDR: next_r.rdData = {3'h0, r.condSel};
                ECD_STAT_ADDR: next_r.rdData = {5'h00,
                    r.st != ECD_IDLE, r.fault, r.done};
                default: next_r.rdData = 8'h00;
            endcase
        end
        if (bus.wr && bus.addr == ECD_WEN_ADDR)
            next_r.wen = bus.wdata[ECD_WEN_BIT];
        if (bus.wr && bus.addr == ECD_COND_ADDR)
            next_r.condSel = bus.wdata[4:0];
        if (!r.strapTaken)
        begin
            next_r.strapTaken = 1'b1;
            next_r.strap = conditionStrapPins;
        end
        case (r.st)
            ECD_IDLE:
            begin
                if (startDl)
                begin
                    next_r.cond = !r.strapTaken ? conditionStrapPins
                        : (r.condSel != 5'h00 ? r.condSel
                        : r.strap);
                    next_r.tags = 32'h0000_0000;
                    next_r.eePtr = '0;
                    next_r.fault = 1'b0;
                    next_r.done = 1'b0;
                    next_r.st = ECD_DL_OP;
                end
                else if (startUp)
                begin
                    next_r.fault = 1'b0;
                    next_r.done = 1'b0;
                    next_r.st = ECD_UP_OP;
                end
            end
            ECD_DL_OP:
            begin
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.exec = execNow;
                if (rdByte == ECD_OP_END)
                begin
                    next_r.eePtr = '0;
                    next_r.done = !r.fault;
                    next_r.st = ECD_IDLE;
                end
                else if (rdByte == ECD_OP_NULL)
                    next_r.tags = 32'h0000_0000;
                else if (isCond(rdByte))
                    next_r.tags[condIdx] = 1'b1;
                else if (rdByte == ECD_OP_IOUPD)
                    next_r.ioUpd = execNow;
                else if (rdByte == ECD_OP_CAL)
                    next_r.cal = execNow;
                else if (isData(rdByte))
                begin
                    next_r.cnt = rdByte;
                    next_r.st = ECD_DL_AH;
                end
            end
            ECD_DL_AH:
            begin
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.tgt[15:8] = rdByte;
                next_r.st = ECD_DL_AL;
            end
            ECD_DL_AL:
            begin
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.tgt[7:0] = rdByte;
                next_r.sum = 8'h00;
                next_r.st = ECD_DL_DAT;
            end
            ECD_DL_DAT:
            begin
                // skipped transfers are still walked byte by byte
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.map.wr = r.exec;
                next_r.map.addr = r.tgt;
                next_r.map.data = rdByte;
                next_r.tgt = r.tgt + 16'h0001;
                next_r.sum = r.sum + rdByte;
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00)
                    next_r.st = ECD_DL_CK;
            end
            ECD_DL_CK:
            begin
                next_r.eePtr = r.eePtr + 1'b1;
                if (r.exec && rdByte != r.sum)
                    next_r.fault = 1'b1;
                next_r.st = ECD_DL_OP;
            end
            ECD_UP_OP:
            begin
                next_r.spPtr = r.spPtr + 8'h01;
                if (spData == ECD_OP_PAUSE)
                begin
                    // storage pointer kept so the next upload appends
                    next_r.spPtr = 8'h00;
                    next_r.done = 1'b1;
                    next_r.st = ECD_IDLE;
                end
                else
                begin
                    memWe = 1'b1;
                    memData = spData;
                    next_r.eePtr = r.eePtr + 1'b1;
                    if (spData == ECD_OP_END)
                    begin
                        next_r.eePtr = '0;
                        next_r.spPtr = 8'h00;
                        next_r.done = 1'b1;
                        next_r.st = ECD_IDLE;
                    end
                    else if (isData(spData))
                    begin
                        next_r.cnt = spData;
                        next_r.st = ECD_UP_AH;
                    end
                end
            end
            ECD_UP_AH, ECD_UP_AL:
            begin
                memWe = 1'b1;
                memData = spData;
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.spPtr = r.spPtr + 8'h01;
                next_r.sum = 8'h00;
                if (r.st == ECD_UP_AH)
                begin
                    next_r.map.addr[15:8] = spData;
                    next_r.st = ECD_UP_AL;
                end
                else
                begin
                    next_r.map.addr[7:0] = spData;
                    next_r.st = ECD_UP_DAT;
                end
            end
            ECD_UP_DAT:
            begin
                memWe = 1'b1;
                memData = mapRdData;
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.sum = r.sum + mapRdData;
                next_r.map.addr = r.map.addr + 16'h0001;
                next_r.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00)
                    next_r.st = ECD_UP_CK;
            end
            ECD_UP_CK:
            begin
                memWe = 1'b1;
                memData = r.sum;
                next_r.eePtr = r.eePtr + 1'b1;
                next_r.st = ECD_UP_OP;
            end
            default: next_r.st = ECD_IDLE;
        endcase
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            r <= '0;
            r.st <= ECD_IDLE;
        end
        else
            r <= next_r;
    end
    // storage is not reset: it must survive a soft reset
    always_ff @(posedge mclk)
    begin
        if (memWe)
            mem[r.eePtr] <= memData;
    end
    assign busRdData = r.rdData;
    assign spAddr = r.spPtr;
    assign mapPort = r.map;
    assign ioUpdate = r.ioUpd;
    assign calibrate = r.cal;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_condPick;
        startDl && r.strapTaken |=> r.cond == ($past(r.condSel) != 5'h00
            ? $past(r.condSel) : $past(r.strap));
    endproperty
    a_condPick: assert property (p_condPick)
        else $error("wrong active condition");
    property p_tagSet;
        r.st == ECD_DL_OP && isCond(rdByte) && rdByte != ECD_OP_NULL
            |=> r.tags[$past(condIdx)] && r.tags[0] == 1'b0;
    endproperty
    a_tagSet: assert property (p_tagSet)
        else $error("condition not tagged");
    property p_tagClr;
        r.st == ECD_DL_OP && rdByte == ECD_OP_NULL |=> r.tags == '0;
    endproperty
    a_tagClr: assert property (p_tagClr)
        else $error("tag board not cleared");
    property p_skip;
        r.st == ECD_DL_OP && rdByte == ECD_OP_IOUPD && r.cond != 5'h00
            && r.tags != '0 && !r.tags[r.cond] |=> !ioUpdate;
    endproperty
    a_skip: assert property (p_skip)
        else $error("untagged update executed");
    property p_nullRun;
        r.st == ECD_DL_OP && rdByte == ECD_OP_CAL && r.cond == 5'h00
            |=> calibrate ##1 (calibrate == ($past(rdByte) == ECD_OP_CAL));
    endproperty
    a_nullRun: assert property (p_nullRun)
        else $error("null condition did not calibrate");
    property p_end;
        r.st == ECD_DL_OP && rdByte == ECD_OP_END
            |=> r.st == ECD_IDLE && r.eePtr == '0;
    endproperty
    a_end: assert property (p_end)
        else $error("end not executed");
    property p_upCopy;
        r.st == ECD_UP_OP && isCond(spData) |-> memWe && memData == spData
            ##1 r.st == ECD_UP_OP;
    endproperty
    a_upCopy: assert property (p_upCopy)
        else $error("condition code altered on upload");
    property p_fault;
        r.st == ECD_DL_CK && r.exec && rdByte != r.sum |=> r.fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("checksum mismatch missed");
    property p_save;
        startUp |=> r.st == ECD_UP_OP && spAddr == $past(spAddr);
    endproperty
    a_save: assert property (p_save)
        else $error("upload not started");
    property p_noAuto;
        !r.strapTaken && conditionStrapPins == 5'h00 && !bus.wr
            |=> r.st == ECD_IDLE;
    endproperty
    a_noAuto: assert property (p_noAuto)
        else $error("auto download with null straps");
    property p_dlClr;
        startDl |=> r.tags == '0 && !r.fault && r.st == ECD_DL_OP;
    endproperty
    a_dlClr: assert property (p_dlClr)
        else $error("download start not clean");
    c_auto: cover property (!r.strapTaken && conditionStrapPins != 5'h00
        ##1 r.st == ECD_DL_OP);
    c_skipData: cover property (r.st == ECD_DL_DAT && !r.exec);
    c_fault: cover property ($rose(r.fault));
    c_append: cover property (r.st == ECD_UP_OP && spData == ECD_OP_PAUSE);
endmodule // ecd_download_ctrl

// File: ecd_far_model.sv
`timescale 1ns/10ps
module ecd_far_model (
    // clock
    input wire logic mclk,
    // scratch pad side
    input wire logic [7:0] spAddr,
    output logic [7:0] spData,
    // register map side
    input ecd_pkg::ecd_map_t mapPort,
    output logic [7:0] mapRdData
);
    import ecd_pkg::*;
    logic [7:0] sp [256];
    logic [7:0] regs [256];
    // only the low address byte decodes: the bench uses a small window
    assign spData = sp[spAddr];
    assign mapRdData = regs[mapPort.addr[7:0]];
    always @(posedge mclk)
    begin
        if (mapPort.wr === 1'b1)
        begin
            regs[mapPort.addr[7:0]] <= mapPort.data;
        end
    end
endmodule // ecd_far_model

// File: ecd_download_ctrl_tb.sv
`timescale 1ns/10ps
module ecd_download_ctrl_tb;
    import ecd_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    ecd_bus_t bus = '0;
    logic [4:0] straps = 5'h00;
    logic [7:0] busRdData, spAddr, spData, mapRdData;
    ecd_map_t mapPort;
    logic ioUpdate, calibrate;
    int err_count = 0;
    int checks_done = 0;
    int ioCnt = 0;
    int calCnt = 0;
    int wrCnt = 0;
    // first setup ends in pause, the second one in end
    logic [7:0] seqA [9] = '{8'h00, 8'h00, 8'h10, 8'hB1, 8'h01, 8'h00,
        8'h20, 8'h80, 8'hFE};
    logic [7:0] seqB [10] = '{8'hB0, 8'hB2, 8'hB3, 8'h00, 8'h00, 8'h30,
        8'h0A, 8'hB0, 8'h80, 8'hFF};

    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        ioCnt += (ioUpdate === 1'b1);
        calCnt += (calibrate === 1'b1);
        wrCnt += (mapPort.wr === 1'b1);
    end

    ecd_download_ctrl dut_u (
        .mclk(mclk), .rst(rst), .bus(bus), .busRdData(busRdData),
        .conditionStrapPins(straps), .spAddr(spAddr), .spData(spData),
        .mapPort(mapPort), .mapRdData(mapRdData), .ioUpdate(ioUpdate),
        .calibrate(calibrate)
    );
    ecd_far_model far_u (
        .mclk(mclk), .spAddr(spAddr), .spData(spData),
        .mapPort(mapPort), .mapRdData(mapRdData)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus <= '0;
        #1 d = busRdData;
    endtask

    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 200; i++)
        begin
            rd(ECD_STAT_ADDR, s);
            if (s[2] === 1'b0)
            begin
                return;
            end
        end
        $display("CHECK FAILED busy wait expected 00 seen %h", s);
        err_count++;
        tally_and_finish();
    endtask

    // entered at time zero or just after a rising edge: two edges see rst
    task automatic do_reset(input logic [4:0] s);
        rst <= 1'b1;
        straps <= s;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // off the edge so the pulse counters never race the clearing
    task automatic clear_targets();
        @(negedge mclk);
        far_u.regs[8'h10] = 8'h00;
        far_u.regs[8'h20] = 8'h00;
        far_u.regs[8'h21] = 8'h00;
        far_u.regs[8'h30] = 8'h00;
        ioCnt = 0;
        calCnt = 0;
        wrCnt = 0;
    endtask

    task automatic check_result(input logic [2:0] m, input int w, io, cal);
        logic [7:0] s;
        rd(ECD_STAT_ADDR, s);
        chk("status", 8'h01, s);
        chk("map10", m[0] ? 8'hA1 : 8'h00, far_u.regs[8'h10]);
        chk("map20", m[1] ? 8'hB2 : 8'h00, far_u.regs[8'h20]);
        chk("map21", m[1] ? 8'hC3 : 8'h00, far_u.regs[8'h21]);
        chk("map30", m[2] ? 8'hD4 : 8'h00, far_u.regs[8'h30]);
        chk("map writes", 8'(w), 8'(wrCnt));
        chk("ioUpdate", 8'(io), 8'(ioCnt));
        chk("calibrate", 8'(cal), 8'(calCnt));
    endtask

    task automatic t_after_reset();
        logic [7:0] d;
        rd(ECD_STAT_ADDR, d);
        chk("status after reset", 8'h00, d);
        rd(ECD_SAVE_ADDR, d);
        chk("save readback", 8'h00, d);
        rd(16'h0E7F, d);
        chk("unmapped read", 8'h00, d);
        wr(ECD_SAVE_ADDR, 8'h01);
        rd(ECD_STAT_ADDR, d);
        chk("save without enable", 8'h00, d);
        chk("pulses idle", 8'h00, {6'h00, ioUpdate, calibrate});
    endtask

    task automatic t_upload();
        logic [7:0] d;
        clear_targets();
        far_u.regs[8'h10] = 8'hA1;
        far_u.regs[8'h20] = 8'hB2;
        far_u.regs[8'h21] = 8'hC3;
        far_u.regs[8'h30] = 8'hD4;
        wr(ECD_WEN_ADDR, 8'h01);
        foreach (seqA[i]) far_u.sp[i] = seqA[i];
        wr(ECD_SAVE_ADDR, 8'h01);
        wait_idle();
        foreach (seqB[i]) far_u.sp[i] = seqB[i];
        wr(ECD_SAVE_ADDR, 8'h01);
        wait_idle();
        rd(ECD_STAT_ADDR, d);
        chk("upload status", 8'h01, d);
        chk("upload pulses", 8'h00, 8'(ioCnt + calCnt + wrCnt));
    endtask

    task automatic t_load(input logic [4:0] sel, input logic [2:0] m,
                          input int w, io, cal);
        logic [7:0] d;
        wr(ECD_COND_ADDR, {3'b000, sel});
        rd(ECD_COND_ADDR, d);
        chk("select readback", {3'b000, sel}, d);
        clear_targets();
        wr(ECD_LOAD_ADDR, 8'h02);
        wait_idle();
        check_result(m, w, io, cal);
    endtask

    // straps of three run the untagged first transfer and the B3-tagged part of the second setup without any register write
    task automatic t_auto();
        clear_targets();
        @(posedge mclk);
        do_reset(5'h03);
        wait_idle();
        check_result(3'b101, 2, 1, 1);
    endtask

    task automatic fault_load(input logic [4:0] sel, input logic [7:0] st,
                              input int w);
        logic [7:0] d;
        wr(ECD_COND_ADDR, {3'b000, sel});
        clear_targets();
        wr(ECD_LOAD_ADDR, 8'h02);
        wait_idle();
        rd(ECD_STAT_ADDR, d);
        chk("fault status", st, d);
        chk("fault writes", 8'(w), 8'(wrCnt));
    endtask

    // a short paused sequence over a longer one shifts the byte framing,
    // so the old checksum byte no longer matches the misread transfer
    task automatic t_fault();
        logic [7:0] d;
        wr(ECD_WEN_ADDR, 8'h01);
        rd(ECD_WEN_ADDR, d);
        chk("enable readback", 8'h01, d);
        far_u.regs[8'h20] = 8'hB2;
        far_u.regs[8'h21] = 8'hC3;
        far_u.sp[0] = 8'h01;
        far_u.sp[1] = 8'h00;
        far_u.sp[2] = 8'h20;
        far_u.sp[3] = 8'hFF;
        wr(ECD_SAVE_ADDR, 8'h01);
        wait_idle();
        far_u.sp[0] = 8'hB1;
        far_u.sp[1] = 8'hFE;
        wr(ECD_SAVE_ADDR, 8'h01);
        wait_idle();
        fault_load(5'h01, 8'h02, 1);
        fault_load(5'h02, 8'h01, 0);
    endtask

    initial
    begin
        do_reset(5'h00);
        t_after_reset();
        t_upload();
        t_load(5'h00, 3'b111, 4, 2, 1);
        t_load(5'h01, 3'b011, 3, 2, 0);
        t_load(5'h02, 3'b101, 2, 1, 1);
        t_load(5'h03, 3'b101, 2, 1, 1);
        t_load(5'h1F, 3'b001, 1, 1, 0);
        t_auto();
        t_load(5'h00, 3'b101, 2, 1, 1);
        t_load(5'h01, 3'b011, 3, 2, 0);
        t_fault();
        tally_and_finish();
    end
endmodule // ecd_download_ctrl_tb
